//--- hdl/prog_stage_pkg.sv
package prog_stage_pkg;

	localparam int MEAS_W = 32;
	localparam int NUM_CH = 3;
	localparam int HYST_W = 16;
	localparam int DELAY_W = 20;
	localparam int TIME_W = 32;
	localparam int CNT_W = 16;
	localparam int GROUP_W = 3;

	// hysteresis and relative pick-up in units of 0.01 %
	localparam longint HYST_SCALE = 64'sd10000;
	localparam logic [HYST_W-1:0] HYST_DEFAULT = 16'h012c;
	// ratio magnitude/setting in units of 0.001
	localparam longint RATIO_SCALE = 64'sd1000;

	localparam int DELTA_WINDOW_MS = 20;
	localparam int CYCLE_MS_DEFAULT = 5;
	localparam int HIST_DEPTH = 12;

	typedef enum logic [2:0] {
		MODE_OVER = 3'h0,
		MODE_OVER_ABS = 3'h1,
		MODE_UNDER = 3'h2,
		MODE_UNDER_ABS = 3'h3,
		MODE_DELTA_PCT = 3'h4,
		MODE_DELTA_PCT_ABS = 3'h5,
		MODE_DELTA_VAL = 3'h6,
		MODE_DELTA_VAL_ABS = 3'h7
	} mode_type;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_RUN = 4'h2,
		ST_TRIP = 4'h4,
		ST_REL = 4'h8
	} state_type;

	// event index within the on/off vectors
	localparam int EV_START = 0;
	localparam int EV_TRIP = 1;
	localparam int EV_BLOCK = 2;
	localparam int EV_NUM = 3;

	localparam logic [1:0] REC_START = 2'h0;
	localparam logic [1:0] REC_TRIP = 2'h1;
	localparam logic [1:0] REC_BLOCK = 2'h2;

	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [DELAY_W-1:0] DELAY_RESET = 20'h00000;

endpackage : prog_stage_pkg

//--- hdl/programmable_stage.sv
`timescale 1ns/1ps
`default_nettype none

module programmable_stage
	import prog_stage_pkg::*;
#(
	parameter int CYCLE_MS = CYCLE_MS_DEFAULT
) (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic cycle_tick_in,
	input wire logic [prog_stage_pkg::TIME_W-1:0] time_ms_in,
	input wire logic [prog_stage_pkg::GROUP_W-1:0] setting_group_in,
	input wire logic signed [prog_stage_pkg::MEAS_W-1:0] meas_in [prog_stage_pkg::NUM_CH],
	input wire logic [1:0] meas_count_in,
	input wire prog_stage_pkg::mode_type mode_in [prog_stage_pkg::NUM_CH],
	input wire logic signed [prog_stage_pkg::MEAS_W-1:0] pickup_in [prog_stage_pkg::NUM_CH],
	input wire logic [prog_stage_pkg::HYST_W-1:0] hyst_in [prog_stage_pkg::NUM_CH],
	input wire logic signed [prog_stage_pkg::MEAS_W-1:0] block_limit_in [prog_stage_pkg::NUM_CH],
	input wire logic [prog_stage_pkg::DELAY_W-1:0] oper_delay_in,
	input wire logic [prog_stage_pkg::DELAY_W-1:0] rel_delay_in,
	input wire logic blocking_in,
	input wire logic [prog_stage_pkg::EV_NUM-1:0] ev_on_en_in,
	input wire logic [prog_stage_pkg::EV_NUM-1:0] ev_off_en_in,
	input wire logic cnt_clear_in,
	input wire logic [3:0] hist_idx_in,
	output logic start_out,
	output logic trip_out,
	output logic blocked_out,
	output logic [prog_stage_pkg::EV_NUM-1:0] ev_on_out,
	output logic [prog_stage_pkg::EV_NUM-1:0] ev_off_out,
	output logic [prog_stage_pkg::TIME_W-1:0] ev_time_out,
	output logic [prog_stage_pkg::DELAY_W-1:0] remain_out,
	output logic [prog_stage_pkg::CNT_W-1:0] start_cnt_out,
	output logic [prog_stage_pkg::CNT_W-1:0] trip_cnt_out,
	output logic [prog_stage_pkg::CNT_W-1:0] blocked_cnt_out,
	output logic [3:0] hist_count_out,
	output logic [prog_stage_pkg::TIME_W-1:0] hist_time_out,
	output logic [1:0] hist_event_out,
	output logic signed [prog_stage_pkg::MEAS_W-1:0] hist_mag_out,
	output logic signed [prog_stage_pkg::MEAS_W-1:0] hist_ratio_out,
	output logic [prog_stage_pkg::DELAY_W-1:0] hist_remain_out,
	output logic [prog_stage_pkg::GROUP_W-1:0] hist_group_out
);
	import prog_stage_pkg::*;

	localparam int WIN = DELTA_WINDOW_MS / CYCLE_MS;

	if (CYCLE_MS < 1 || WIN < 1 || (DELTA_WINDOW_MS % CYCLE_MS) != 0) begin : g_bad_cycle
		$error("program cycle must divide the delta window");
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic signed [63:0] abs64(input logic signed [63:0] v);
		abs64 = (v < 0) ? -v : v;
	endfunction : abs64

	function automatic logic eval_cond(
		input mode_type m,
		input logic signed [MEAS_W-1:0] v32,
		input logic signed [MEAS_W-1:0] old32,
		input logic signed [MEAS_W-1:0] lvl32,
		input logic signed [MEAS_W-1:0] lim32,
		input logic [HYST_W-1:0] hyst,
		input logic prev
	);
		logic signed [63:0] v;
		logic signed [63:0] old;
		logic signed [63:0] lvl;
		logic signed [63:0] band;
		logic signed [63:0] thr_g;
		logic signed [63:0] thr_l;
		logic signed [63:0] delta;
		logic above_lim;
		v = 64'(v32);
		old = 64'(old32);
		lvl = 64'(lvl32);
		band = (abs64(lvl) * $signed({48'h0, hyst})) / HYST_SCALE;
		thr_g = prev ? lvl - band : lvl;
		thr_l = prev ? lvl + band : lvl;
		delta = v - old;
		above_lim = v >= 64'(lim32);
		unique case (m)
			MODE_OVER: eval_cond = v > thr_g;
			MODE_OVER_ABS: eval_cond = abs64(v) > thr_g;
			MODE_UNDER: eval_cond = (v < thr_l) && above_lim;
			MODE_UNDER_ABS: eval_cond = (abs64(v) < thr_l) && above_lim;
			MODE_DELTA_PCT: begin
				if (lvl >= 0) begin
					eval_cond = delta * HYST_SCALE > thr_g * abs64(old);
				end else begin
					eval_cond = delta * HYST_SCALE < thr_l * abs64(old);
				end
			end
			MODE_DELTA_PCT_ABS: eval_cond = abs64(delta) * HYST_SCALE > thr_g * abs64(old);
			MODE_DELTA_VAL: eval_cond = (lvl >= 0) ? (delta > thr_g) : (delta < thr_l);
			MODE_DELTA_VAL_ABS: eval_cond = abs64(delta) > thr_g;
		endcase
	endfunction : eval_cond

	////////////////////////////////////////////////////////////////////////////////
	// sampling at the start of each program cycle
	logic signed [MEAS_W-1:0] samp_ff [NUM_CH];
	logic signed [MEAS_W-1:0] nxt_samp [NUM_CH];
	logic signed [MEAS_W-1:0] win_ff [NUM_CH][WIN];
	logic signed [MEAS_W-1:0] nxt_win [NUM_CH][WIN];
	logic blk_ff;
	logic nxt_blk;
	logic eval_ff;
	logic nxt_eval;
	logic [NUM_CH-1:0] cond_ff;
	logic [NUM_CH-1:0] nxt_cond;
	logic pick;

	always_comb begin
		nxt_samp = samp_ff;
		nxt_win = win_ff;
		nxt_blk = blk_ff;
		nxt_cond = cond_ff;
		nxt_eval = cycle_tick_in;
		pick = 1'b0;
		if (cycle_tick_in) begin
			nxt_samp = meas_in;
			nxt_blk = blocking_in;
		end
		for (int c = 0; c < NUM_CH; c++) begin
			if (c == 0 || c < int'(meas_count_in)) begin
				pick = pick | cond_ff[c];
			end
			if (eval_ff) begin
				nxt_cond[c] = eval_cond(mode_in[c], samp_ff[c], win_ff[c][WIN-1], pickup_in[c],
					block_limit_in[c], hyst_in[c], cond_ff[c]);
				nxt_win[c][0] = samp_ff[c];
				for (int k = 1; k < WIN; k++) begin
					nxt_win[c][k] = win_ff[c][k-1];
				end
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			for (int c = 0; c < NUM_CH; c++) begin
				samp_ff[c] <= '0;
				for (int k = 0; k < WIN; k++) begin
					win_ff[c][k] <= '0;
				end
			end
			blk_ff <= 1'b0;
			eval_ff <= 1'b0;
			cond_ff <= '0;
		end else begin
			samp_ff <= nxt_samp;
			win_ff <= nxt_win;
			blk_ff <= nxt_blk;
			eval_ff <= nxt_eval;
			cond_ff <= nxt_cond;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// start / trip / blocked sequencing, one step per program cycle
	logic decide_ff;
	state_type state_ff;
	state_type nxt_state;
	logic [DELAY_W-1:0] op_cnt_ff;
	logic [DELAY_W-1:0] nxt_op_cnt;
	logic [DELAY_W-1:0] rel_cnt_ff;
	logic [DELAY_W-1:0] nxt_rel_cnt;
	logic trip_ff;
	logic nxt_trip;
	logic blocked_ff;
	logic nxt_blocked;
	logic go;
	logic nxt_start;

	always_comb begin
		nxt_state = state_ff;
		nxt_op_cnt = op_cnt_ff;
		nxt_rel_cnt = rel_cnt_ff;
		nxt_trip = trip_ff;
		nxt_blocked = blocked_ff;
		go = pick && !blk_ff;
		if (decide_ff) begin
			unique case (state_ff)
				ST_IDLE: begin
					if (go) begin
						nxt_state = ST_RUN;
						nxt_op_cnt = DELAY_RESET;
					end
				end
				ST_RUN: begin
					if (!go) begin
						nxt_state = ST_REL;
						nxt_rel_cnt = DELAY_RESET;
					end else if (op_cnt_ff + 20'h00001 >= oper_delay_in) begin
						nxt_state = ST_TRIP;
						nxt_trip = 1'b1;
					end else begin
						nxt_op_cnt = op_cnt_ff + 20'h00001;
					end
				end
				ST_TRIP: begin
					if (!go) begin
						nxt_state = ST_REL;
						nxt_rel_cnt = DELAY_RESET;
					end
				end
				ST_REL: begin
					if (go) begin
						nxt_state = trip_ff ? ST_TRIP : ST_RUN;
					end else if (rel_cnt_ff + 20'h00001 >= rel_delay_in) begin
						nxt_state = ST_IDLE;
						nxt_trip = 1'b0;
						nxt_op_cnt = DELAY_RESET;
					end else begin
						nxt_rel_cnt = rel_cnt_ff + 20'h00001;
					end
				end
			endcase
			// blocked pick-up is only flagged, never timed
			nxt_blocked = pick && blk_ff;
		end
		nxt_start = (nxt_state == ST_RUN) || (nxt_state == ST_TRIP);
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			decide_ff <= 1'b0;
			state_ff <= ST_IDLE;
			op_cnt_ff <= DELAY_RESET;
			rel_cnt_ff <= DELAY_RESET;
			trip_ff <= 1'b0;
			blocked_ff <= 1'b0;
			start_out <= 1'b0;
			trip_out <= 1'b0;
			blocked_out <= 1'b0;
			remain_out <= DELAY_RESET;
		end else begin
			decide_ff <= eval_ff;
			state_ff <= nxt_state;
			op_cnt_ff <= nxt_op_cnt;
			rel_cnt_ff <= nxt_rel_cnt;
			trip_ff <= nxt_trip;
			blocked_ff <= nxt_blocked;
			start_out <= nxt_start;
			trip_out <= nxt_trip;
			blocked_out <= nxt_blocked;
			remain_out <= (nxt_state == ST_RUN) ? oper_delay_in - nxt_op_cnt : DELAY_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// events and cumulative counters
	logic [EV_NUM-1:0] now_vec;
	logic [EV_NUM-1:0] was_vec;
	logic [EV_NUM-1:0] rise;
	logic [EV_NUM-1:0] fall;
	logic [CNT_W-1:0] nxt_start_cnt;
	logic [CNT_W-1:0] nxt_trip_cnt;
	logic [CNT_W-1:0] nxt_blocked_cnt;

	always_comb begin
		now_vec = {nxt_blocked, nxt_trip, nxt_start};
		was_vec = {blocked_ff, trip_ff, start_out};
		rise = now_vec & ~was_vec;
		fall = ~now_vec & was_vec;
		// an occurrence in the clear cycle still counts
		nxt_start_cnt = cnt_clear_in ? CNT_RESET : start_cnt_out;
		nxt_trip_cnt = cnt_clear_in ? CNT_RESET : trip_cnt_out;
		nxt_blocked_cnt = cnt_clear_in ? CNT_RESET : blocked_cnt_out;
		if (rise[EV_START]) begin
			nxt_start_cnt = nxt_start_cnt + 16'h0001;
		end
		if (rise[EV_TRIP]) begin
			nxt_trip_cnt = nxt_trip_cnt + 16'h0001;
		end
		if (rise[EV_BLOCK]) begin
			nxt_blocked_cnt = nxt_blocked_cnt + 16'h0001;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			ev_on_out <= '0;
			ev_off_out <= '0;
			ev_time_out <= '0;
			start_cnt_out <= CNT_RESET;
			trip_cnt_out <= CNT_RESET;
			blocked_cnt_out <= CNT_RESET;
		end else begin
			ev_on_out <= rise & ev_on_en_in;
			ev_off_out <= fall & ev_off_en_in;
			ev_time_out <= time_ms_in;
			start_cnt_out <= nxt_start_cnt;
			trip_cnt_out <= nxt_trip_cnt;
			blocked_cnt_out <= nxt_blocked_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// operation history, newest at read index 0
	logic [TIME_W-1:0] h_time [HIST_DEPTH];
	logic [1:0] h_event [HIST_DEPTH];
	logic signed [MEAS_W-1:0] h_mag [HIST_DEPTH];
	logic signed [MEAS_W-1:0] h_ratio [HIST_DEPTH];
	logic [DELAY_W-1:0] h_remain [HIST_DEPTH];
	logic [GROUP_W-1:0] h_group [HIST_DEPTH];
	logic [3:0] wptr_ff;
	logic [3:0] nxt_wptr;
	logic [3:0] nxt_hcount;
	logic [3:0] rd_slot;
	logic rec_we;
	logic [1:0] rec_event;
	logic signed [MEAS_W-1:0] rec_ratio;
	logic signed [63:0] ratio_wide;

	always_comb begin
		rec_we = |rise;
		rec_event = rise[EV_TRIP] ? REC_TRIP : (rise[EV_START] ? REC_START : REC_BLOCK);
		if (pickup_in[0] == '0) begin
			ratio_wide = '0;
		end else begin
			ratio_wide = (64'(samp_ff[0]) * RATIO_SCALE) / 64'(pickup_in[0]);
		end
		rec_ratio = ratio_wide[MEAS_W-1:0];
		nxt_wptr = wptr_ff;
		nxt_hcount = hist_count_out;
		if (rec_we) begin
			nxt_wptr = (wptr_ff == 4'(HIST_DEPTH - 1)) ? 4'h0 : wptr_ff + 4'h1;
			if (hist_count_out != 4'(HIST_DEPTH)) begin
				nxt_hcount = hist_count_out + 4'h1;
			end
		end
		if (hist_idx_in >= wptr_ff) begin
			rd_slot = 4'(HIST_DEPTH) + wptr_ff - 4'h1 - hist_idx_in;
		end else begin
			rd_slot = wptr_ff - 4'h1 - hist_idx_in;
		end
		if (rd_slot >= 4'(HIST_DEPTH)) begin
			rd_slot = 4'h0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rec_we) begin
			h_time[wptr_ff] <= time_ms_in;
			h_event[wptr_ff] <= rec_event;
			h_mag[wptr_ff] <= samp_ff[0];
			h_ratio[wptr_ff] <= rec_ratio;
			h_remain[wptr_ff] <= (nxt_state == ST_RUN) ? oper_delay_in - nxt_op_cnt : DELAY_RESET;
			h_group[wptr_ff] <= setting_group_in;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			wptr_ff <= 4'h0;
			hist_count_out <= 4'h0;
			hist_time_out <= '0;
			hist_event_out <= 2'h0;
			hist_mag_out <= '0;
			hist_ratio_out <= '0;
			hist_remain_out <= DELAY_RESET;
			hist_group_out <= '0;
		end else begin
			wptr_ff <= nxt_wptr;
			hist_count_out <= nxt_hcount;
			if (hist_idx_in < hist_count_out) begin
				hist_time_out <= h_time[rd_slot];
				hist_event_out <= h_event[rd_slot];
				hist_mag_out <= h_mag[rd_slot];
				hist_ratio_out <= h_ratio[rd_slot];
				hist_remain_out <= h_remain[rd_slot];
				hist_group_out <= h_group[rd_slot];
			end else begin
				hist_time_out <= '0;
				hist_event_out <= 2'h0;
				hist_mag_out <= '0;
				hist_ratio_out <= '0;
				hist_remain_out <= DELAY_RESET;
				hist_group_out <= '0;
			end
		end
	end

endmodule : programmable_stage

`default_nettype wire

//--- testbench/meas_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module meas_src_model
	import prog_stage_pkg::*;
#(
	parameter int TICK_CLKS = 8,
	parameter int CYCLE_MS = CYCLE_MS_DEFAULT
) (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic signed [prog_stage_pkg::MEAS_W-1:0] meas_set_in [prog_stage_pkg::NUM_CH],
	input wire logic block_set_in,
	output logic cycle_tick_out,
	output logic [prog_stage_pkg::TIME_W-1:0] time_ms_out,
	output logic signed [prog_stage_pkg::MEAS_W-1:0] meas_out [prog_stage_pkg::NUM_CH],
	output logic blocking_out
);
	int cnt;
	always @(negedge core_clk_in) begin
		if (srst_in) begin
			cnt <= 0;
			cycle_tick_out <= 1'b0;
			time_ms_out <= '0;
			meas_out <= '{default: '0};
			blocking_out <= 1'b0;
		end else begin
			cnt <= (cnt == TICK_CLKS - 1) ? 0 : cnt + 1;
			cycle_tick_out <= (cnt == TICK_CLKS - 1);
			if (cnt == TICK_CLKS - 1)
				time_ms_out <= time_ms_out + TIME_W'(CYCLE_MS);
			// new samples land mid cycle, clear of the tick
			if (cnt == 2) begin
				meas_out <= meas_set_in;
				blocking_out <= block_set_in;
			end
		end
	end
endmodule : meas_src_model
`default_nettype wire

//--- testbench/prog_stage_sva.sv
`timescale 1ns/1ps
`default_nettype none
module prog_stage_sva
	import prog_stage_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic cycle_tick_in,
	input wire logic cnt_clear_in,
	input wire logic [prog_stage_pkg::EV_NUM-1:0] ev_on_en_in,
	input wire logic [prog_stage_pkg::EV_NUM-1:0] ev_off_en_in,
	input wire logic start_out,
	input wire logic trip_out,
	input wire logic blocked_out,
	input wire logic [prog_stage_pkg::EV_NUM-1:0] ev_on_out,
	input wire logic [prog_stage_pkg::EV_NUM-1:0] ev_off_out,
	input wire logic [prog_stage_pkg::CNT_W-1:0] start_cnt_out,
	input wire logic [prog_stage_pkg::CNT_W-1:0] trip_cnt_out,
	input wire logic [3:0] hist_count_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	////////////////////////////////
	start_excl_a: assert property (!(start_out && blocked_out))
		else $error("start and blocked high together");
	tick_align_a: assert property ($changed({start_out, trip_out, blocked_out})
		|-> $past(cycle_tick_in, 2) || $past(cycle_tick_in, 3))
		else $error("stage outputs moved away from a program cycle");
	trip_start_a: assert property ($rose(trip_out) |-> start_out)
		else $error("trip rose without start");
	start_on_a: assert property ($rose(start_out) && ev_on_en_in[EV_START]
		|-> ev_on_out[EV_START])
		else $error("start on event missing");
	block_on_a: assert property ($rose(blocked_out) && ev_on_en_in[EV_BLOCK]
		|-> ev_on_out[EV_BLOCK])
		else $error("blocked on event missing");
	start_off_a: assert property ($fell(start_out) && ev_off_en_in[EV_START]
		|-> ev_off_out[EV_START])
		else $error("start off event missing");
	trip_off_mask_a: assert property (!ev_off_en_in[EV_TRIP] |-> !ev_off_out[EV_TRIP])
		else $error("disabled trip off event emitted");
	start_count_a: assert property ($rose(start_out) && !$past(cnt_clear_in)
		|-> start_cnt_out == $past(start_cnt_out) + 16'h1)
		else $error("start counter did not step");
	trip_count_a: assert property ($rose(trip_out) && !$past(cnt_clear_in)
		|-> trip_cnt_out == $past(trip_cnt_out) + 16'h1)
		else $error("trip counter did not step");
	hist_cap_a: assert property (hist_count_out <= 4'hc)
		else $error("history count above twelve");
	cover property ($rose(trip_out));
	cover property ($fell(trip_out));
	cover property ($rose(blocked_out));
endmodule : prog_stage_sva

bind programmable_stage prog_stage_sva i_sva (
	.core_clk_in(core_clk_in), .srst_in(srst_in), .cycle_tick_in(cycle_tick_in),
	.cnt_clear_in(cnt_clear_in), .ev_on_en_in(ev_on_en_in), .ev_off_en_in(ev_off_en_in),
	.start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
	.ev_on_out(ev_on_out), .ev_off_out(ev_off_out), .start_cnt_out(start_cnt_out),
	.trip_cnt_out(trip_cnt_out), .hist_count_out(hist_count_out)
);
`default_nettype wire

//--- testbench/programmable_stage_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module programmable_stage_tb_top;
	import prog_stage_pkg::*;
	typedef struct {
		mode_type m;
		logic signed [15:0] pk;
		logic signed [15:0] lim;
		logic signed [15:0] base;
		logic signed [15:0] stp;
		logic e;
	} row_type;
	row_type rows [15] = '{
		'{MODE_OVER, 16'sh64, 16'sh0, 16'sh0, 16'sh65, 1'b1},
		'{MODE_OVER, 16'sh64, 16'sh0, 16'sh0, 16'sh64, 1'b0},
		'{MODE_OVER, -16'sh32, 16'sh0, -16'sh64, -16'sh28, 1'b1},
		'{MODE_OVER_ABS, 16'sh64, 16'sh0, 16'sh0, -16'sh96, 1'b1},
		'{MODE_OVER, 16'sh64, 16'sh0, 16'sh0, -16'sh96, 1'b0},
		'{MODE_UNDER, 16'sh64, 16'sha, 16'shc8, 16'sh32, 1'b1},
		'{MODE_UNDER, 16'sh64, 16'sha, 16'shc8, 16'sh5, 1'b0},
		'{MODE_UNDER_ABS, 16'sh64, -16'sh1f4, 16'shc8, -16'sh32, 1'b1},
		'{MODE_UNDER_ABS, 16'sh64, 16'sh0, 16'shc8, -16'sh32, 1'b0},
		'{MODE_DELTA_PCT, 16'sh3e8, 16'sh0, 16'sh3e8, 16'sh4b0, 1'b1},
		'{MODE_DELTA_PCT, 16'sh3e8, 16'sh0, 16'sh3e8, 16'sh320, 1'b0},
		'{MODE_DELTA_PCT_ABS, 16'sh3e8, 16'sh0, 16'sh3e8, 16'sh320, 1'b1},
		'{MODE_DELTA_VAL, 16'sh32, 16'sh0, 16'sh3e8, 16'sh44c, 1'b1},
		'{MODE_DELTA_VAL, -16'sh32, 16'sh0, 16'sh3e8, 16'sh44c, 1'b0},
		'{MODE_DELTA_VAL_ABS, 16'sh32, 16'sh0, 16'sh3e8, 16'sh384, 1'b1}
	};
	logic core_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic tick, blk, st, tr, bl;
	logic [TIME_W-1:0] tms;
	logic signed [MEAS_W-1:0] mset [NUM_CH];
	logic signed [MEAS_W-1:0] meas [NUM_CH];
	mode_type mode [NUM_CH];
	logic signed [MEAS_W-1:0] pk [NUM_CH];
	logic [HYST_W-1:0] hyst [NUM_CH];
	logic signed [MEAS_W-1:0] lim [NUM_CH];
	logic [1:0] mcnt = 2'h1;
	logic [DELAY_W-1:0] opd = 20'hc8;
	logic [DELAY_W-1:0] rld = 20'h0;
	logic bset = 1'b0;
	logic clr = 1'b0;
	logic [3:0] hidx = 4'h0;
	logic [CNT_W-1:0] scnt, tcnt, bcnt;
	logic [3:0] hcnt;
	logic [1:0] hev;
	logic signed [MEAS_W-1:0] hmag, hratio;
	logic [GROUP_W-1:0] hgrp;
	logic [TIME_W-1:0] evt;
	logic [TIME_W-1:0] htime;
	logic [TIME_W-1:0] t_trip;
	logic [DELAY_W-1:0] rem;
	logic [DELAY_W-1:0] hrem;
	int bad_count = 0;
	int compares = 0;
	always #2.5 core_clk_in = ~core_clk_in;
	meas_src_model i_model (
		.core_clk_in(core_clk_in), .srst_in(srst_in), .meas_set_in(mset),
		.block_set_in(bset), .cycle_tick_out(tick), .time_ms_out(tms),
		.meas_out(meas), .blocking_out(blk)
	);
	programmable_stage i_dut (
		.core_clk_in(core_clk_in), .srst_in(srst_in), .cycle_tick_in(tick),
		.time_ms_in(tms), .setting_group_in(3'h5), .meas_in(meas),
		.meas_count_in(mcnt), .mode_in(mode), .pickup_in(pk), .hyst_in(hyst),
		.block_limit_in(lim), .oper_delay_in(opd), .rel_delay_in(rld),
		.blocking_in(blk), .ev_on_en_in(3'h7), .ev_off_en_in(3'h5),
		.cnt_clear_in(clr), .hist_idx_in(hidx), .start_out(st), .trip_out(tr),
		.blocked_out(bl), .ev_on_out(), .ev_off_out(), .ev_time_out(evt),
		.remain_out(rem), .start_cnt_out(scnt), .trip_cnt_out(tcnt),
		.blocked_cnt_out(bcnt), .hist_count_out(hcnt), .hist_time_out(htime),
		.hist_event_out(hev), .hist_mag_out(hmag), .hist_ratio_out(hratio),
		.hist_remain_out(hrem), .hist_group_out(hgrp)
	);
	////////////////////////////////
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// returns once the decision of the n-th next tick has landed
	task automatic tw(input int n);
		repeat (n) begin
			do @(posedge core_clk_in); while (tick !== 1'b1);
		end
		repeat (4) @(posedge core_clk_in);
		@(negedge core_clk_in);
	endtask : tw
	task automatic rd(input logic [3:0] idx);
		hidx = idx;
		repeat (2) @(negedge core_clk_in);
	endtask : rd
	task automatic stop_test();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	////////////////////////////////
	initial begin
		#50us;
		bad_count++;
		stop_test();
	end
	initial begin
		for (int i = 0; i < NUM_CH; i++) begin
			mode[i] = MODE_OVER;
			pk[i] = 32'sh000f4240;
			hyst[i] = HYST_DEFAULT;
			lim[i] = 32'sh0;
			mset[i] = 32'sh0;
		end
		repeat (16) @(negedge core_clk_in);
		srst_in <= 1'b0;
		chk({st, tr, bl, scnt, hcnt}, 23'h0);
		foreach (rows[i]) begin
			mode[0] = rows[i].m;
			pk[0] = rows[i].pk;
			lim[0] = rows[i].lim;
			mset[0] = rows[i].base;
			tw(8);
			chk(st, 1'b0);
			mset[0] = rows[i].stp;
			tw(2);
			chk(st, rows[i].e);
		end
		// hysteresis band below an over level
		mode[0] = MODE_OVER;
		pk[0] = 32'sh3e8;
		lim[0] = 32'sh0;
		mset[0] = 32'sh0;
		tw(8);
		mset[0] = 32'sh44c;
		tw(2);
		chk(st, 1'b1);
		mset[0] = 32'sh3d4;
		tw(2);
		chk(st, 1'b1);
		mset[0] = 32'sh3c0;
		tw(2);
		chk(st, 1'b0);
		hyst[0] = 16'h0;
		mset[0] = 32'sh44c;
		tw(2);
		mset[0] = 32'sh3de;
		tw(2);
		chk(st, 1'b0);
		hyst[0] = HYST_DEFAULT;
		mset[0] = 32'sh0;
		// second channel only counts when enabled
		pk[1] = 32'sh3e8;
		mset[1] = 32'sh44c;
		tw(3);
		chk(st, 1'b0);
		mcnt = 2'h2;
		tw(2);
		chk(st, 1'b1);
		mcnt = 2'h1;
		mset[1] = 32'sh0;
		tw(3);
		clr = 1'b1;
		repeat (2) @(negedge core_clk_in);
		clr = 1'b0;
		chk({scnt, tcnt, bcnt}, 48'h0);
		opd = 20'h3;
		rld = 20'h2;
		// a new sample reaches the stage only on the second tick
		mset[0] = 32'sh44c;
		tw(2);
		chk({st, tr}, 2'h2);
		chk(rem, 20'h3);
		chk(evt, tms);
		tw(2);
		chk(tr, 1'b0);
		chk(rem, 20'h1);
		tw(1);
		chk(tr, 1'b1);
		bset = 1'b1;
		tw(2);
		chk({st, bl, tr}, 3'h3);
		tw(1);
		chk(tr, 1'b1);
		tw(2);
		chk(tr, 1'b0);
		mset[0] = 32'sh0;
		tw(2);
		chk(bl, 1'b0);
		mset[0] = 32'sh44c;
		tw(2);
		chk({st, bl}, 2'h1);
		tw(4);
		chk({st, tr}, 2'h0);
		chk({scnt, tcnt, bcnt}, 48'h000100010002);
		rd(4'h0);
		chk({hev, hgrp}, {REC_BLOCK, 3'h5});
		chk({hmag, hratio}, 64'h0000044c0000044c);
		rd(4'h2);
		chk(hev, REC_TRIP);
		t_trip = htime;
		rd(4'h3);
		chk(hev, REC_START);
		chk(hrem, 20'h3);
		chk(t_trip - htime, TIME_W'(3 * CYCLE_MS_DEFAULT));
		chk(hcnt, 4'hc);
		rd(4'hc);
		chk(hmag, 32'sh0);
		stop_test();
	end
endmodule : programmable_stage_tb_top
`default_nettype wire
